// ===== hw/regsleep_pkg.sv
// Package: register map, field positions, reset values and timing constants
package regsleep_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CONTROL_OFF = 8'h00;
  localparam logic [7:0] REG_SLEEP_OFF = 8'h04;
  localparam logic [7:0] REG_CAUSE_OFF = 8'h08;
  localparam logic [7:0] REG_STATUS_OFF = 8'h0C;
  localparam logic [7:0] REG_MASK_OFF = 8'h10;
  localparam logic [7:0] REG_TIMING_OFF = 8'h14;
  // ==========================================================================
  // Control register fields
  localparam int LPWR_BIT = 15;
  localparam int PLL_LVL_LSB = 4;
  localparam int CORE_B_LVL_LSB = 2;
  localparam int CORE_A_LVL_LSB = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_MASK = 16'h803F;
  // Level codes
  localparam logic [1:0] LVL_NOM_A = 2'h3;
  localparam logic [1:0] LVL_NOM_B = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_LOW = 2'h1;
  // Decoded level outputs: 0 = 1.2V, 1 = 1.0V, 2 = 0.8V
  localparam logic [1:0] VOUT_1V2 = 2'h0;
  localparam logic [1:0] VOUT_1V0 = 2'h1;
  localparam logic [1:0] VOUT_0V8 = 2'h2;
  // ==========================================================================
  // Sleep flag register: bit0 master notify, bit1 slave notify
  localparam int NOTIFY_M_BIT = 0;
  localparam int NOTIFY_S_BIT = 1;
  // Cause register: bit1 brown-out, bit0 power-on
  localparam int CAUSE_BOR_BIT = 1;
  localparam int CAUSE_POR_BIT = 0;
  localparam logic [1:0] CAUSE_RESET = 2'h1;
  // Status/mask: bit0 brown-out, bit1 both asleep, bit2 reset released
  localparam int EV_BOR = 0;
  localparam int EV_SLEEP = 1;
  localparam int EV_RELEASE = 2;
  localparam int EV_W = 3;
  // Timing register: bit0 oscillator mode, bit1 pll, bit2 crystal
  localparam int T_OSC_BIT = 0;
  localparam int T_PLL_BIT = 1;
  localparam int T_XTAL_BIT = 2;
  localparam int T_POWER_UP_TIMER_BIT = 3;
  // Power-up delay enabled out of reset, other timing options off
  localparam logic [3:0] TIMING_RESET = 4'h8;
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int OST_CYC = 1024;
  localparam int POWER_UP_TIMER_CYC = 2048;
  localparam int FSCM_CYC = 512;
endpackage

// ===== hw/regulator_sleep_and_brownout_ctrl.sv
// Regulator control, dual-core sleep handshake and brown-out reset sequencer
module regulator_sleep_and_brownout_ctrl #(
  parameter int OST_CYCLES = regsleep_pkg::OST_CYC,
  parameter int POWER_UP_TIMER_CYCLES = regsleep_pkg::POWER_UP_TIMER_CYC,
  parameter int FSCM_CYCLES = regsleep_pkg::FSCM_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic brownout_pin,
  input wire logic pll_lock_pin,
  input wire logic master_sleep,
  input wire logic slave_sleep,
  output logic low_power_mode,
  output logic [1:0] pll_vout_sel,
  output logic [1:0] core_b_vout_sel,
  output logic [1:0] core_a_vout_sel,
  output logic core_reg_shutdown,
  output logic device_reset_pulse,
  output logic clock_hold,
  output logic internal_reset,
  output logic irq
);
  // ==========================================================================
  // Input synchronisers; first stages feed only second stages
  logic bor_s1_reg, bor_s2_reg, lock_s1_reg, lock_s2_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bor_s1_reg <= 1'b0;
      bor_s2_reg <= 1'b0;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end
    else
    begin
      bor_s1_reg <= brownout_pin;
      bor_s2_reg <= bor_s1_reg;
      lock_s1_reg <= pll_lock_pin;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;
  logic access;
  assign access = hsel && hready && htrans[1];
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= access && hwrite;
      rd_pend_reg <= access && !hwrite;
      if (access)
        addr_reg <= haddr[7:0];
    end
  end
  logic wr_ctl, wr_slp, wr_cause, wr_stat, wr_mask, wr_tim;
  assign wr_ctl = wr_pend_reg && addr_reg == regsleep_pkg::REG_CONTROL_OFF;
  assign wr_slp = wr_pend_reg && addr_reg == regsleep_pkg::REG_SLEEP_OFF;
  assign wr_cause = wr_pend_reg && addr_reg == regsleep_pkg::REG_CAUSE_OFF;
  assign wr_stat = wr_pend_reg && addr_reg == regsleep_pkg::REG_STATUS_OFF;
  assign wr_mask = wr_pend_reg && addr_reg == regsleep_pkg::REG_MASK_OFF;
  assign wr_tim = wr_pend_reg && addr_reg == regsleep_pkg::REG_TIMING_OFF;

  // ==========================================================================
  // Regulator control; unimplemented bits never stored
  logic [15:0] control_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      control_reg <= regsleep_pkg::CONTROL_RESET;
    else if (wr_ctl)
      control_reg <= hwdata[15:0] & regsleep_pkg::CONTROL_MASK;
  end

  // Level decode shared by all three fields
  function automatic logic [1:0] decode_level(input logic [1:0] code);
    case (code)
      regsleep_pkg::LVL_MID: decode_level = regsleep_pkg::VOUT_1V0;
      regsleep_pkg::LVL_LOW: decode_level = regsleep_pkg::VOUT_0V8;
      default: decode_level = regsleep_pkg::VOUT_1V2;
    endcase
  endfunction

  // Regulator outputs, registered; shutdown only with both cores asleep
  logic both_asleep;
  assign both_asleep = master_sleep && slave_sleep;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      low_power_mode <= 1'b0;
      pll_vout_sel <= regsleep_pkg::VOUT_1V2;
      core_b_vout_sel <= regsleep_pkg::VOUT_1V2;
      core_a_vout_sel <= regsleep_pkg::VOUT_1V2;
      core_reg_shutdown <= 1'b0;
    end
    else
    begin
      low_power_mode <= control_reg[regsleep_pkg::LPWR_BIT];
      pll_vout_sel <= decode_level(
        control_reg[regsleep_pkg::PLL_LVL_LSB +: 2]);
      core_b_vout_sel <= decode_level(
        control_reg[regsleep_pkg::CORE_B_LVL_LSB +: 2]);
      core_a_vout_sel <= decode_level(
        control_reg[regsleep_pkg::CORE_A_LVL_LSB +: 2]);
      // Low-power request alone never stops a core that is still awake
      core_reg_shutdown <= both_asleep
        && control_reg[regsleep_pkg::LPWR_BIT];
    end
  end

  // ==========================================================================
  // Inter-core notify flags: plain read/write bits both cores can see
  logic [1:0] notify_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      notify_reg <= 2'h0;
    else if (wr_slp)
      notify_reg <= hwdata[1:0];
  end

  // Timing options: oscillator, PLL, crystal, power-up delay enable
  logic [3:0] timing_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      timing_reg <= regsleep_pkg::TIMING_RESET;
    else if (wr_tim)
      timing_reg <= hwdata[3:0];
  end

  // ==========================================================================
  // Brown-out sequencer; watched in every mode, sleep and idle included
  typedef enum logic [2:0] {
    ST_RUN, ST_PULSE, ST_WAIT, ST_DONE
  } seq_state_type;
  seq_state_type state_reg;
  logic [15:0] clk_cnt_reg, dly_cnt_reg;
  logic clk_ok, dly_ok, bor_event, release_event;
  assign bor_event = bor_s2_reg && state_reg == ST_RUN;
  // Clock wait: timer in oscillator mode, lock when the PLL is used
  assign clk_ok = (!timing_reg[regsleep_pkg::T_OSC_BIT]
      || clk_cnt_reg >= 16'(OST_CYCLES))
    && (!timing_reg[regsleep_pkg::T_PLL_BIT] || lock_s2_reg);
  // Power-up delay, or monitor delay with crystal and no power-up delay
  assign dly_ok = timing_reg[regsleep_pkg::T_POWER_UP_TIMER_BIT]
    ? dly_cnt_reg >= 16'(POWER_UP_TIMER_CYCLES)
    : (!timing_reg[regsleep_pkg::T_XTAL_BIT]
      || dly_cnt_reg >= 16'(FSCM_CYCLES));
  assign release_event = state_reg == ST_WAIT && clk_ok && dly_ok;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= ST_RUN;
      clk_cnt_reg <= 16'h0000;
      dly_cnt_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          clk_cnt_reg <= 16'h0000;
          dly_cnt_reg <= 16'h0000;
          if (bor_event)
            state_reg <= ST_PULSE;
        end
        ST_PULSE:
        begin
          clk_cnt_reg <= clk_cnt_reg + 16'h0001;
          if (clk_cnt_reg == 16'(regsleep_pkg::RESET_PULSE_CYC - 1))
          begin
            state_reg <= ST_WAIT;
            clk_cnt_reg <= 16'h0000;
          end
        end
        ST_WAIT:
        begin
          // Both waits run concurrently; counters and the exit to ST_DONE wait for supply, internal_reset does not
          if (bor_s2_reg)
          begin
            clk_cnt_reg <= 16'h0000;
            dly_cnt_reg <= 16'h0000;
          end
          else
          begin
            if (!clk_ok)
              clk_cnt_reg <= clk_cnt_reg + 16'h0001;
            if (!dly_ok)
              dly_cnt_reg <= dly_cnt_reg + 16'h0001;
            if (clk_ok && dly_ok)
              state_reg <= ST_DONE;
          end
        end
        ST_DONE:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Reset outputs from flops
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      device_reset_pulse <= 1'b0;
      clock_hold <= 1'b0;
      internal_reset <= 1'b0;
    end
    else
    begin
      device_reset_pulse <= bor_event
        || (state_reg == ST_PULSE && clk_cnt_reg
          != 16'(regsleep_pkg::RESET_PULSE_CYC - 1));
      clock_hold <= bor_event || state_reg == ST_PULSE
        || (state_reg == ST_WAIT && !(clk_ok && !bor_s2_reg));
      internal_reset <= bor_event || state_reg == ST_PULSE
        || (state_reg == ST_WAIT && !release_event);
    end
  end

  // ==========================================================================
  // Reset cause flags; hardware set wins over software write
  logic [1:0] cause_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cause_reg <= regsleep_pkg::CAUSE_RESET;
    else
    begin
      if (wr_cause)
        cause_reg <= hwdata[1:0];
      if (bor_event)
        cause_reg[regsleep_pkg::CAUSE_BOR_BIT] <= 1'b1;
    end
  end

  // Interrupt status, write one to clear, set wins
  logic [regsleep_pkg::EV_W-1:0] status_reg, mask_reg, ev;
  logic sleep_d_reg;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sleep_d_reg <= 1'b0;
    else
      sleep_d_reg <= both_asleep;
  end
  assign ev = {release_event, both_asleep && !sleep_d_reg, bor_event};
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      status_reg <= '0;
      mask_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status_reg <= (status_reg
        & ~(wr_stat ? hwdata[regsleep_pkg::EV_W-1:0] : '0)) | ev;
      if (wr_mask)
        mask_reg <= hwdata[regsleep_pkg::EV_W-1:0];
      irq <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================================
  // Read data driven during data phase from flops
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      hrdata <= 32'h00000000;
    else if (access && !hwrite)
    begin
      case (haddr[7:0])
        regsleep_pkg::REG_CONTROL_OFF: hrdata <= {16'h0000, control_reg};
        regsleep_pkg::REG_SLEEP_OFF: hrdata <= {30'h0, notify_reg};
        regsleep_pkg::REG_CAUSE_OFF: hrdata <= {30'h0, cause_reg};
        regsleep_pkg::REG_STATUS_OFF: hrdata <= {29'h0, status_reg};
        regsleep_pkg::REG_MASK_OFF: hrdata <= {29'h0, mask_reg};
        regsleep_pkg::REG_TIMING_OFF: hrdata <= {28'h0, timing_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_bor_seen;
    bor_event;
  endsequence
  a_bor_pulse_out: assert property (@(posedge ref_clk) disable iff (reset)
    s_bor_seen |=> device_reset_pulse && internal_reset)
    else $error("brown-out gave no reset pulse");
  a_bor_cause_set: assert property (@(posedge ref_clk) disable iff (reset)
    s_bor_seen |=> cause_reg[1])
    else $error("brown-out cause bit not set");
  a_lpwr_follow: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ctl |=> ##1 low_power_mode == $past(hwdata[15], 2))
    else $error("low-power output wrong");
  a_pll_level: assert property (@(posedge ref_clk) disable iff (reset)
    control_reg[5:4] == 2'h1 |=> pll_vout_sel == 2'h2)
    else $error("pll level decode wrong");
  a_core_b_level: assert property (@(posedge ref_clk) disable iff (reset)
    control_reg[3:2] == 2'h2 |=> core_b_vout_sel == 2'h1)
    else $error("core b level decode wrong");
  a_core_a_level: assert property (@(posedge ref_clk) disable iff (reset)
    control_reg[1:0] == 2'h0 |=> core_a_vout_sel == 2'h0)
    else $error("core a level decode wrong");
  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (reset)
    control_reg[14:6] == 9'h000)
    else $error("unimplemented bits stored");
  a_shutdown_gate: assert property (@(posedge ref_clk) disable iff (reset)
    core_reg_shutdown |-> $past(both_asleep))
    else $error("shutdown with a core awake");
  a_hold_lock: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == ST_WAIT && timing_reg[1] && !lock_s2_reg
      |=> clock_hold)
    else $error("clock released before lock");
  a_sleep_watch: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == ST_RUN && bor_s2_reg && both_asleep
      |=> state_reg == ST_PULSE)
    else $error("brown-out missed in sleep");
endmodule // regulator_sleep_and_brownout_ctrl

// ===== testbench/sleep_partner.sv
// Partner model: the two processor cores entering and leaving Sleep
module sleep_partner (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] req,
  output logic master_sleep,
  output logic slave_sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  logic notify_reg;
  // ==========================================================
  // Request codes: 0 wake, 1 slave first, 2 notify then slave then master, 3 slave only
  // Clock slowing and PWM shutdown are software steps, not modelled
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      notify_reg <= 1'b0;
      slave_sleep <= 1'b0;
      master_sleep <= 1'b0;
    end
    else
    begin
      case (req)
        2'h1:
        begin
          slave_sleep <= 1'b1;
          master_sleep <= slave_sleep;
        end
        2'h2:
        begin
          notify_reg <= 1'b1;
          slave_sleep <= notify_reg;
          master_sleep <= slave_sleep;
        end
        2'h3: slave_sleep <= 1'b1;
        default:
        begin
          notify_reg <= 1'b0;
          slave_sleep <= 1'b0;
          master_sleep <= 1'b0;
        end
      endcase
    end
  end
endmodule // sleep_partner

// ===== testbench/regulator_sleep_and_brownout_ctrl_tb_top.sv
// Testbench: register access, sleep handshake and brown-out sequencing
module regulator_sleep_and_brownout_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, hsel, hwrite, hready, bo_pin, lock;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, req, pll_v, cb_v, ca_v, e;
  logic [2:0] hsize;
  logic hreadyout, hresp, lpm, shut, rpulse, chold, ireset, irq, msl, ssl;
  int fails, check_count, n, pw, ir;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  // ==========================================================
  // Clock and instances
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  regulator_sleep_and_brownout_ctrl #(.OST_CYCLES(8), .POWER_UP_TIMER_CYCLES(16),
    .FSCM_CYCLES(4)) dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .brownout_pin(bo_pin),
    .pll_lock_pin(lock), .master_sleep(msl), .slave_sleep(ssl),
    .low_power_mode(lpm), .pll_vout_sel(pll_v), .core_b_vout_sel(cb_v),
    .core_a_vout_sel(ca_v), .core_reg_shutdown(shut),
    .device_reset_pulse(rpulse), .clock_hold(chold),
    .internal_reset(ireset), .irq(irq));
  sleep_partner cores (.ref_clk(ref_clk), .reset(reset), .req(req),
    .master_sleep(msl), .slave_sleep(ssl));
  // ==========================================================
  // Checking and closing
  task tally_and_finish;
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait for a level; a hang ends the run as a failure
  task automatic wait_on(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (s !== v)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  task automatic span(ref logic s, output int c);
    c = 0;
    while (s === 1'b1 && c < 5000)
    begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    // A level that never drops is a hang: fail the run
    if (s === 1'b1)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  // ==========================================================
  // AHB-Lite single word transfer, held until ready is sampled high
  task rdy;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rdat = hrdata;
    hsel <= 1'b0;
  endtask
  // Brown-out with a timing setup; returns pulse and release spans
  task brown(input logic [3:0] tm);
    xfer(1'b1, 8'h14, {28'h0000000, tm});
    @(posedge ref_clk);
    bo_pin <= 1'b1;
    wait_on(rpulse, 1'b1, 20);
    chk(chold, 1'b1);
    chk(ireset, 1'b1);
    span(rpulse, pw);
    @(posedge ref_clk);
    bo_pin <= 1'b0;
    span(ireset, ir);
    chk(pw, regsleep_pkg::RESET_PULSE_CYC);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    reset = 1'b1;
    {hsel, hwrite, bo_pin, lock, htrans, req} = '0;
    haddr = '0;
    hwdata = '0;
    hsize = 3'h2;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h00000000);
    chk(lpm, 1'b0);
    // Notify flags: one core writes, the other reads back
    xfer(1'b1, 8'h04, 32'h00000002);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h00000002);
    chk(hresp, 1'b0);
    xfer(1'b1, 8'h00, 32'hFFFFFFFF);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0000803F);
    tick(2);
    chk(lpm, 1'b1);
    // Same code in all fields, every code
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b1, 8'h00, {26'h0, c[1:0], c[1:0], c[1:0]});
      tick(2);
      e = (c == 2) ? regsleep_pkg::VOUT_1V0 :
          (c == 1) ? regsleep_pkg::VOUT_0V8 : regsleep_pkg::VOUT_1V2;
      chk(pll_v, e);
      chk(cb_v, e);
      chk(ca_v, e);
      chk(lpm, 1'b0);
    end
    // Distinct codes catch swapped fields
    xfer(1'b1, 8'h00, 32'h00000024);
    tick(2);
    chk(pll_v, regsleep_pkg::VOUT_1V0);
    chk(cb_v, regsleep_pkg::VOUT_0V8);
    chk(ca_v, regsleep_pkg::VOUT_1V2);
    // Low power and reduced levels first, then slave alone asleep
    xfer(1'b1, 8'h00, 32'h00008015);
    @(posedge ref_clk);
    req <= 2'h3;
    tick(4);
    chk(shut, 1'b0);
    @(posedge ref_clk);
    req <= 2'h1;
    tick(4);
    chk(shut, 1'b1);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(rdat[1], 1'b1);
    @(posedge ref_clk);
    req <= 2'h0;
    tick(3);
    chk(shut, 1'b0);
    xfer(1'b1, 8'h00, 32'h0000803F);
    xfer(1'b1, 8'h00, 32'h0000003F);
    xfer(1'b1, 8'h00, 32'h0000802A);
    @(posedge ref_clk);
    req <= 2'h2;
    tick(5);
    chk(shut, 1'b1);
    // Brown-out while both cores sleep
    brown(4'h0);
    @(posedge ref_clk);
    req <= 2'h0;
    // Cause bit cleared by software, then set by a brown-out
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h0C, 32'h00000007);
    xfer(1'b1, 8'h10, 32'h0);
    brown(4'h9);
    chk(ir >= 16, 1'b1);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rdat[1], 1'b1);
    chk(irq, 1'b0);
    xfer(1'b1, 8'h10, 32'h00000001);
    tick(2);
    chk(irq, 1'b1);
    xfer(1'b1, 8'h0C, 32'h00000001);
    tick(2);
    chk(irq, 1'b0);
    // Crystal without power-up delay: only the short monitor delay
    brown(4'h4);
    chk(ir >= 4 && ir < 16, 1'b1);
    // PLL: clock stays held until lock is seen
    fork
      begin
        repeat (80) @(posedge ref_clk);
        chk(chold, 1'b1);
        lock <= 1'b1;
      end
    join_none
    brown(4'h2);
    chk(chold, 1'b0);
    tally_and_finish;
  end
endmodule // regulator_sleep_and_brownout_ctrl_tb_top
